/* tb.sv */
/* Testbench for tpwm_core. Assumes a count clock of four system clocks. */
`timescale 1ns/1ps
module tb;
   logic clk_i = 0, rst_n_i = 0, cclk = 0, start_i = 0, mode8_i = 0, pin, irq;
   logic [15:0] treg = 16'h0000;
   int hi, p, h, miscompares = 0, total_checks = 0;
   always #5 clk_i = ~clk_i;
   always #20 cclk = ~cclk;
   tpwm_core dut (.clk_i(clk_i), .rst_n_i(rst_n_i), .selected_count_clock_i(cclk),
      .start_i(start_i), .mode8_i(mode8_i), .timer_reg_i(treg),
      .pwm_output_pin_o(pin), .irq_o(irq));
   tpwm_load u_load (.clk_i(clk_i), .pin_i(pin), .hi_o(hi));
   task ck(string n, logic [31:0] e, logic [31:0] s);
      total_checks++;
      if (e !== s) begin
         miscompares++;
         $display("CHECK FAILED %s expected %0d seen %0d", n, e, s);
      end
   endtask : ck
   // Drop enable first so the prescaler restarts cleanly
   task cfg(logic m, logic [15:0] r);
      @(posedge clk_i); #1 start_i = 0;
      repeat (4) @(posedge clk_i);
      #1 start_i = 1; mode8_i = m; treg = r;
   endtask : cfg
   task meas(int e, int eh);
      int w, h0;
      w = 0; p = 0; h0 = hi;
      while (irq !== 1'b1 && w < 2100) begin @(posedge clk_i); #1 w++; end
      if (irq === 1'b1) begin
         h0 = hi;
         do begin @(posedge clk_i); #1 p++; end while (irq !== 1'b1 && p < 2100);
      end
      h = hi - h0;
      ck("period", e, p);
      ck("high", eh, h);
   endtask : meas
   task s_pwm;
      cfg(1, 16'h0200); meas(1020, 8);
      cfg(1, 16'h0301); meas(2040, 24);
   endtask : s_pwm
   task s_zero;
      cfg(1, 16'h0000); meas(0, 0);
      cfg(0, 16'h0000); meas(0, 0);
   endtask : s_zero
   task s_hib;
      cfg(1, 16'h00FF); meas(0, 0);
   endtask : s_hib
   // Start just after a count-clock rise: the first step lands two edges
   // after start, so the first high portion is 16 steps less two clocks
   task s_p16;
      int h0, irqs;
      irqs = 0;
      @(posedge clk_i); #1 start_i = 0;
      repeat (4) @(posedge clk_i);
      @(posedge cclk);
      @(posedge clk_i); #1 start_i = 1; mode8_i = 0; treg = 16'h0010;
      h0 = hi;
      repeat (300) begin @(posedge clk_i); #1 if (irq === 1'b1) irqs++; end
      ck("high16", 4 * 16 - 2, hi - h0);
      ck("irq16", 0, irqs);
   endtask : s_p16
   task stop_test;
      $display("miscompares %0d total_checks %0d", miscompares, total_checks);
      if (miscompares == 0 && total_checks > 0) $display("All tests passed");
      else $display("Some tests failed");
      $finish;
   endtask : stop_test
   initial begin
      repeat (10) @(posedge clk_i);
      #1 rst_n_i = 1;
      s_pwm; s_zero; s_hib; s_p16;
      stop_test;
   end
   initial begin #400000 miscompares++; stop_test; end
endmodule : tb

/* tpwm_core.sv */
/*
 * Timer channel in pulse-width-modulation mode, 8-bit and 16-bit.
 * In 8-bit mode the low byte of the timer register divides the count
 * clock and the high byte sets the high width; in 16-bit mode the whole
 * register is the high width and the period is fixed.
 * A zero register, or a zero high byte in 8-bit mode, idles the channel.
 * Assumes the selected count clock arrives as an asynchronous level
 * whose high and low phases each last at least two clk_i cycles, and
 * that the timer register value, the mode and the enable are static
 * configuration from the clk_i domain, changed only while start_i is low.
 * The counter starts at zero on the first clk_i edge that sees start_i
 * high, so the first period after a start is short by the edge-detect lag.
 */
`timescale 1ns/1ps
// Function
// - 8-bit period is 255 times (m+1)
// - 8-bit high width is (m+1) times n
// - Zero timer register stops the counter
// - Zero register: no interrupt, no pulse
// - Zero register in PWM: output held low
// - Zero register in PWM: never interrupt
// - 8-bit mode: zero high byte idles too
module tpwm_core
   import tpwm_pkg::*;
(
   input wire logic clk_i,                      // System clock, 100 MHz
   input wire logic rst_n_i,                    // Async reset, active low
   input wire logic selected_count_clock_i,     // Count clock, async
   input wire logic start_i,                    // Count enable
   input wire logic mode8_i,                    // 1: 8-bit mode, 0: 16-bit
   input wire logic [TPWM_REG_W-1:0] timer_reg_i, // Timer register value
   output logic pwm_output_pin_o,               // PWM output
   output logic irq_o                           // Period-end pulse
);
   // Count-clock path
   logic cclk_s;
   logic cclk_d_r;
   logic tick;

   // Fields of the timer register, and the mode
   logic [7:0] pre_m;
   logic [7:0] hi_n;
   logic [15:0] width16;
   tpwm_mode_e mode;

   // Idle decode
   logic reg_zero;
   logic hi_zero;
   logic idle;

   // Prescaler
   logic [7:0] pre_cnt_r;
   logic [7:0] pre_cnt_nxt;
   logic pre_hit;
   logic pre_tick;

   // Period counter
   logic [15:0] cnt_r;
   logic [15:0] cnt_nxt;
   logic last8;
   logic last16;
   logic last;

   // Output stage
   logic pin8;
   logic pin16;
   logic pin_nxt;
   logic irq_nxt;

   tpwm_sync u_sync (
      .clk_i(clk_i),
      .rst_n_i(rst_n_i),
      .d_i(selected_count_clock_i),
      .q_o(cclk_s)
   );

   assign pre_m = timer_reg_i[TPWM_LO_LSB +: TPWM_BYTE_W];
   assign hi_n = timer_reg_i[TPWM_HI_LSB +: TPWM_BYTE_W];
   assign width16 = timer_reg_i;
   assign mode = mode8_i ? TPWM_MODE8 : TPWM_MODE16;

   assign reg_zero = (timer_reg_i == TPWM_ZERO16);
   assign hi_zero = (mode == TPWM_MODE8) && (hi_n == TPWM_ZERO8);
   // A zero width would only give empty pulses, so the channel idles
   // instead: pin low, no interrupt, counters held at zero
   assign idle = !start_i || reg_zero || hi_zero;

   // Resets low like the synchroniser, so no false tick follows reset
   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         cclk_d_r <= 1'b0;
      end else begin
         cclk_d_r <= cclk_s;
      end
   end
   assign tick = cclk_s && !cclk_d_r;

   // Prescaler divides the count clock by m+1 in 8-bit mode only
   assign pre_hit = (pre_cnt_r == pre_m);
   always_comb begin
      case (mode)
         TPWM_MODE8: begin
            pre_tick = tick && pre_hit;
         end
         TPWM_MODE16: begin
            pre_tick = tick;
         end
         default: begin
            pre_tick = 1'b0;
         end
      endcase
   end

   // Held at zero while idle so an 8-bit restart waits m+1 ticks for its first step
   always_comb begin
      pre_cnt_nxt = pre_cnt_r;
      if (idle) begin
         pre_cnt_nxt = TPWM_ZERO8;
      end else if (tick) begin
         if (pre_tick) begin
            pre_cnt_nxt = TPWM_ZERO8;
         end else begin
            pre_cnt_nxt = pre_cnt_r + TPWM_ONE8;
         end
      end
   end

   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         pre_cnt_r <= TPWM_ZERO8;
      end else begin
         pre_cnt_r <= pre_cnt_nxt;
      end
   end

   assign last8 = (cnt_r[7:0] == TPWM_P8_LAST);
   assign last16 = (cnt_r == TPWM_P16_LAST);
   always_comb begin
      case (mode)
         TPWM_MODE8: begin
            last = last8;
         end
         TPWM_MODE16: begin
            last = last16;
         end
         default: begin
            last = 1'b0;
         end
      endcase
   end

   always_comb begin
      cnt_nxt = cnt_r;
      if (idle) begin
         cnt_nxt = TPWM_ZERO16;
      end else if (pre_tick) begin
         if (last) begin
            cnt_nxt = TPWM_ZERO16;
         end else begin
            cnt_nxt = cnt_r + TPWM_ONE16;
         end
      end
   end

   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         cnt_r <= TPWM_ZERO16;
      end else begin
         cnt_r <= cnt_nxt;
      end
   end

   // With n = 255 the pin never falls: the 8-bit count tops out at 254
   assign pin8 = (cnt_r[7:0] < hi_n);
   assign pin16 = (cnt_r < width16);
   always_comb begin
      pin_nxt = 1'b0;
      if (idle) begin
         pin_nxt = 1'b0;
      end else begin
         case (mode)
            TPWM_MODE8: begin
               pin_nxt = pin8;
            end
            TPWM_MODE16: begin
               pin_nxt = pin16;
            end
            default: begin
               pin_nxt = 1'b0;
            end
         endcase
      end
   end

   // Registered so the pin never shows decode glitches
   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         pwm_output_pin_o <= 1'b0;
      end else begin
         pwm_output_pin_o <= pin_nxt;
      end
   end

   assign irq_nxt = !idle && pre_tick && last;

   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         irq_o <= 1'b0;
      end else begin
         irq_o <= irq_nxt;
      end
   end
endmodule : tpwm_core

/* tpwm_core_assertions.sv */
/* Port checker for tpwm_core. Assumes a static configuration. */
`timescale 1ns/1ps
module tpwm_chk import tpwm_pkg::*; (
   input wire logic clk_i, // Clock
   input wire logic rst_n_i, // Reset
   input wire logic selected_count_clock_i, // Count clock
   input wire logic start_i, // Enable
   input wire logic mode8_i, // Mode
   input wire logic [TPWM_REG_W-1:0] timer_reg_i, // Register
   input wire logic pwm_output_pin_o, // Output
   input wire logic irq_o // Period end
);
   default clocking @(posedge clk_i); endclocking
   default disable iff (!rst_n_i);
   wire z = timer_reg_i == TPWM_ZERO16;
   wire hz = mode8_i && timer_reg_i[15:8] == TPWM_ZERO8;
   wire id = !start_i || z || hz;
   // Three cycles let the registered output settle
   sequence idl; id[*3]; endsequence
   zero_stop_a: assert property (z[*3] |-> !pwm_output_pin_o) else $error("pin high");
   zero_irq_a: assert property (z[*3] |-> !irq_o) else $error("irq on zero");
   idle_low_a: assert property (idl |-> !pwm_output_pin_o) else $error("idle pin high");
   idle_irq_a: assert property (idl |-> !irq_o) else $error("idle irq");
   hi_zero_a: assert property (hz[*3] |-> !pwm_output_pin_o && !irq_o) else $error("n zero");
   irq_pulse_a: assert property (irq_o |=> !irq_o) else $error("irq too long");
   // The pin register takes its value from the decode one edge earlier
   rise_cause_a: assert property ($rose(pwm_output_pin_o) |-> !$past(id)) else $error("rise");
   irq_cause_a: assert property (irq_o |-> $past(start_i, 2)) else $error("irq cause");
endmodule : tpwm_chk
bind tpwm_core tpwm_chk u_chk (
   .clk_i(clk_i),
   .rst_n_i(rst_n_i),
   .selected_count_clock_i(selected_count_clock_i),
   .start_i(start_i),
   .mode8_i(mode8_i),
   .timer_reg_i(timer_reg_i),
   .pwm_output_pin_o(pwm_output_pin_o),
   .irq_o(irq_o)
);

/* tpwm_load.sv */
/* Load on the output pin: counts high cycles. Assumes one clock. */
`timescale 1ns/1ps
module tpwm_load (
   input wire logic clk_i, // Clock
   input wire logic pin_i, // Driven pin
   output int hi_o // High cycles seen
);
   initial hi_o = 0;
   always @(posedge clk_i) if (pin_i === 1'b1) hi_o <= hi_o + 1;
endmodule : tpwm_load

/* tpwm_pkg.sv */
/*
 * Constants for the timer pulse-width modulator: register widths, field
 * positions and reset values. Assumes a single 100 MHz system clock.
 */
package tpwm_pkg;
   localparam int unsigned TPWM_REG_W = 16;
   localparam int unsigned TPWM_BYTE_W = 8;
   localparam int unsigned TPWM_LO_LSB = 0;
   localparam int unsigned TPWM_HI_LSB = 8;
   localparam logic [15:0] TPWM_REG_RST = 16'h0000;
   localparam logic [7:0] TPWM_PRE_MAX = 8'hFE;
   // 8-bit period in prescaled ticks is 2^8 - 1
   localparam logic [7:0] TPWM_P8_LAST = 8'hFE;
   // 16-bit period in count-clock cycles is 2^16 - 1
   localparam logic [15:0] TPWM_P16_LAST = 16'hFFFE;
   localparam logic [15:0] TPWM_ZERO16 = 16'h0000;
   localparam logic [7:0] TPWM_ZERO8 = 8'h00;
   localparam logic [7:0] TPWM_ONE8 = 8'h01;
   localparam logic [15:0] TPWM_ONE16 = 16'h0001;
   typedef enum logic {TPWM_MODE16, TPWM_MODE8} tpwm_mode_e;
endpackage : tpwm_pkg

/* tpwm_sync.sv */
/*
 * Two flip-flop synchroniser for a single level.
 * Assumes the input is asynchronous to clk_i.
 */
`timescale 1ns/1ps
module tpwm_sync (
   input wire logic clk_i,    // System clock
   input wire logic rst_n_i,  // Async reset, active low
   input wire logic d_i,      // Asynchronous level
   output logic q_o           // Synchronised level
);
   logic meta_r;
   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         meta_r <= 1'b0;
         q_o <= 1'b0;
      end else begin
         meta_r <= d_i;
         q_o <= meta_r;
      end
   end
endmodule : tpwm_sync
